// *** wwdc_cfg.svh ***
// Constants of the windowed watchdog control block.
// Assumes inclusion by bare name from the package and from each design and bench file.
`ifndef WWDC_CFG_SVH
`define WWDC_CFG_SVH

// Register indices; byte address is four times the index
`define WWDC_IDX_CONTROL  2'h0
`define WWDC_IDX_STATUS   2'h1
`define WWDC_IDX_GUARD    2'h2

// Field positions of the control register
`define WWDC_PERIOD_LSB   0
`define WWDC_PERIOD_MSB   3
`define WWDC_WINDOW_LSB   4
`define WWDC_WINDOW_MSB   7

// Field positions of the status register
`define WWDC_LOCK_BIT     7
`define WWDC_BUSY_BIT     0

// Reset values
`define WWDC_STATUS_RST   8'h00
`define WWDC_CONTROL_RST  8'h00

// Code table: code 1 gives the base length, each code doubles it
`define WWDC_MAX_CODE     4'hB
`define WWDC_BASE_TICKS   14'h0008

// Watchdog clock ticks needed to move a write or a kick across
`define WWDC_XFER_TICKS   2'h2
`define WWDC_KICK_TICKS   2'h2

// Unlock key (arbitrary value) and how many transfers it stays open
`define WWDC_GUARD_KEY    8'hA5
`define WWDC_GUARD_SPAN   3'h4

`endif

// *** wwdc_pkg.sv ***
// Types and helpers shared by the watchdog control files.
// Assumes the constants header sits in the same folder.
package wwdc_pkg;
    `include "wwdc_cfg.svh"

    // Four-bit length code of either field
    typedef logic [3:0] wwdc_code_t;

    // Phase of the watchdog count
    typedef enum logic [1:0] {WWDC_OFF, WWDC_OPEN, WWDC_CLOSED} wwdc_phase_t;

    // Length in watchdog ticks; reserved codes read as zero, i.e. off
    function automatic logic [13:0] wwdc_ticks(input wwdc_code_t code);
        logic [13:0] len;
        len = 14'h0000;
        if ((code != 4'h0) && (code <= `WWDC_MAX_CODE)) begin
            len = `WWDC_BASE_TICKS << (code - 4'h1);
        end
        return len;
    endfunction
endpackage

// *** wwdc_xfer.sv ***
// Moves a control write into the watchdog tick domain.
// Assumes wdtTick is a one-cycle pulse per watchdog clock period.
`timescale 1ns/10ps
`include "wwdc_cfg.svh"
module wwdc_xfer
    import wwdc_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // Watchdog time base
    input  wire logic       wdtTick,
    // Write to move
    input  wire logic       startXfer,
    input  wire logic [7:0] startValue,
    // Boot load, bypasses the transfer
    input  wire logic       bootLoad,
    input  wire logic [7:0] bootValue,
    // Results
    output logic            busy,
    output logic [7:0]      settled
);
    logic       busy_reg, busy_next;      // Transfer in flight
    logic [1:0] wait_reg, wait_next;      // Ticks seen so far
    logic [7:0] shadow_reg, shadow_next;  // Value being moved
    logic [7:0] settled_reg, settled_next;// Value in force

    // A start while busy is dropped; software polls busy first
    wire startTake = startXfer && !busy_reg;
    wire done      = busy_reg && wdtTick && (wait_reg == `WWDC_XFER_TICKS - 2'h1);

    assign busy_next    = startTake || (busy_reg && !done);
    assign wait_next    = startTake ? 2'h0 : (busy_reg && wdtTick) ? wait_reg + 2'h1 : wait_reg;
    assign shadow_next  = startTake ? startValue : shadow_reg;
    assign settled_next = bootLoad ? bootValue : done ? shadow_reg : settled_reg;

    // State registers
    always_ff @(posedge clock) begin
        if (reset) begin
            busy_reg    <= 1'b0;
            wait_reg    <= 2'h0;
            shadow_reg  <= `WWDC_CONTROL_RST;
            settled_reg <= `WWDC_CONTROL_RST;
        end else begin
            busy_reg    <= busy_next;
            wait_reg    <= wait_next;
            shadow_reg  <= shadow_next;
            settled_reg <= settled_next;
        end
    end

    assign busy    = busy_reg;
    assign settled = settled_reg;

    a_xfer_done_lands: assert property (@(posedge clock) disable iff (reset)
        done && !bootLoad |=> !busy_reg && settled_reg == $past(shadow_reg))
        else $error("transfer end did not clear busy or land value");
endmodule

// *** wwdc_kick_sync.sv ***
// Carries a kick into the watchdog tick domain.
// Assumes kickReq is a one-cycle pulse from the processor.
`timescale 1ns/10ps
`include "wwdc_cfg.svh"
module wwdc_kick_sync
    import wwdc_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Time base and control
    input  wire logic wdtTick,
    input  wire logic kickReq,
    input  wire logic flush,
    // Results
    output logic      kickApply,
    output logic      kickBusy
);
    logic       pend_reg, pend_next;  // Kick waiting for ticks
    logic [1:0] wait_reg, wait_next;  // Ticks seen so far

    // A second kick while one is pending is ignored
    wire take = kickReq && !pend_reg && !flush;
    assign kickApply = pend_reg && wdtTick && !flush
                       && (wait_reg == `WWDC_KICK_TICKS - 2'h1);
    assign pend_next = !flush && (take || (pend_reg && !kickApply));
    assign wait_next = take ? 2'h0 : (pend_reg && wdtTick) ? wait_reg + 2'h1 : wait_reg;

    // State registers
    always_ff @(posedge clock) begin
        if (reset) begin
            pend_reg <= 1'b0;
            wait_reg <= 2'h0;
        end else begin
            pend_reg <= pend_next;
            wait_reg <= wait_next;
        end
    end

    assign kickBusy = pend_reg;
endmodule

// *** wwdc_top.sv ***
// Windowed watchdog control: APB registers, lock, guard and timer.
// Assumes wdtTick is a one-cycle pulse at the watchdog clock rate,
// and that all inputs are synchronous to clock.
//
// How it works
// - window code 1 to B turns windowed mode on
// - window code sets closed length, doubling per code
// - period code 1 to B enables the watchdog
// - period code sets normal timeout length
// - in windowed mode period sets open length
// - lock makes control register read-only
// - lock set by software, cleared only debugging
// - boot sets lock when period nonzero
// - lock changes only after guard unlock, or at boot
// - busy rises after each accepted control write
// - busy clears after transfer completes
// - control at index 0, status at 1
// - control register loads from boot fuse
// - missed kick before timeout resets system
// - kick in closed period resets system
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`include "wwdc_cfg.svh"
module wwdc_top
    import wwdc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [3:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Boot and debug
    input  wire logic [7:0]  bootWatchdogFuse,
    input  wire logic        debugMode,
    input  wire logic        cpuHalted,
    // Watchdog time base and kick
    input  wire logic        wdtTick,
    input  wire logic        watchdogKick,
    // System reset request
    output logic             systemResetReq
);
    // Bus decode
    // Only pwdata[7:0] carries data; the upper bits are ignored
    wire        setup    = psel && !penable;       // First bus cycle
    wire        access   = psel && penable;        // Completing cycle
    wire [1:0]  regIdx   = paddr[3:2];             // Word index
    wire        aligned  = (paddr[1:0] == 2'h0);   // Word aligned
    wire        hitCtrl  = aligned && (regIdx == `WWDC_IDX_CONTROL);
    wire        hitStat  = aligned && (regIdx == `WWDC_IDX_STATUS);
    wire        hitGuard = aligned && (regIdx == `WWDC_IDX_GUARD);
    wire        mapped   = hitCtrl || hitStat || hitGuard;
    wire        wrCtrl   = access && pwrite && hitCtrl;
    wire        wrStat   = access && pwrite && hitStat;
    wire        wrGuard  = access && pwrite && hitGuard;

    // Stored state
    // All of it runs on clock; the watchdog time base arrives as wdtTick
    logic [7:0]  control_reg, control_next;  // Control as software sees it
    logic        lock_reg, lock_next;        // Write protection of control
    logic        boot_reg;                   // High for the first cycle
    logic [2:0]  guard_reg, guard_next;      // Transfers left after unlock
    logic [31:0] prdata_reg, prdata_next;    // Read data, held for access
    logic        fire_reg;                   // Registered reset request

    // Timer state
    wwdc_phase_t phase_reg, phase_next;      // Off, open or closed
    logic [13:0] count_reg, count_next;      // Ticks into current phase
    logic        fire;                       // Violation this cycle

    // Cross-domain helpers
    logic        busy;                       // Control write in flight
    logic [7:0]  settled;                    // Control value in force
    logic        kickApply;                  // Kick has reached the timer
    logic        kickBusy;                   // Kick still being carried

    // Boot handling
    wire        bootLoad  = boot_reg;
    wire [3:0]  fusePeriod = bootWatchdogFuse[`WWDC_PERIOD_MSB:`WWDC_PERIOD_LSB];
    wire        bootLock  = boot_reg && (fusePeriod != 4'h0);

    // The guard stands in for the processor's unlock sequence: the key
    // opens it for a few transfers and it then shuts by itself
    // guard opens only on the key
    wire        guardOpen = (guard_reg != 3'h0);
    wire        keyWrite  = wrGuard && (pwdata[7:0] == `WWDC_GUARD_KEY);

    // A refused write gives no bus error; software reads back to see
    // whether it landed
    // locked control ignores writes
    wire        ctrlTake  = wrCtrl && guardOpen && !lock_reg && !busy;

    // Clearing needs debug mode and the guard, so a runaway program
    // cannot switch the watchdog off
    // lock set by one, clear in debug
    wire        lockSet   = wrStat && guardOpen && pwdata[`WWDC_LOCK_BIT];
    wire        lockClr   = wrStat && guardOpen && !pwdata[`WWDC_LOCK_BIT] && debugMode;

    // Status word: lock on top, busy at the bottom, rest zero
    wire [7:0]  statusWord = {lock_reg, 6'h00, busy};

    // Read data are taken in the setup cycle, so a read shows the state
    // one cycle before its access completes; simpler than a late mux
    // Read selection; unmapped reads return zero
    wire [31:0] readMux = hitCtrl  ? {24'h000000, control_reg} :
                          hitStat  ? {24'h000000, statusWord} :
                          hitGuard ? {29'h0000000, guard_reg} :
                          32'h00000000;

    // Control next value
    // Software view only; the timer runs from the settled copy
    // boot fuse loads control
    assign control_next = bootLoad ? bootWatchdogFuse :
                          ctrlTake ? pwdata[7:0] : control_reg;

    // boot sets lock
    // Boot set wins over any software clear in the same cycle
    assign lock_next = bootLock || lockSet || (lock_reg && !lockClr);

    // Guard counts down on each completed transfer after the key
    // The key write itself reloads the count instead of using it up
    assign guard_next = keyWrite ? `WWDC_GUARD_SPAN :
                        (access && guardOpen) ? guard_reg - 3'h1 : guard_reg;

    // Read data captured in the setup cycle
    assign prdata_next = setup ? readMux : prdata_reg;

    // Register state
    always_ff @(posedge clock) begin
        if (reset) begin
            control_reg <= `WWDC_CONTROL_RST;
            lock_reg    <= 1'b0;
            boot_reg    <= 1'b1;
            guard_reg   <= 3'h0;
            prdata_reg  <= 32'h00000000;
        end else begin
            control_reg <= control_next;
            lock_reg    <= lock_next;
            boot_reg    <= 1'b0;
            guard_reg   <= guard_next;
            prdata_reg  <= prdata_next;
        end
    end

    // Bus answers: zero wait states, error on unmapped word
    // pslverr flags holes in the map only; refused writes stay silent
    // index map decoded above
    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // Control write crossing into the tick domain
    // The timer never reads control_reg: a new setting counts only
    // once the transfer has landed and busy has dropped
    wwdc_xfer u_xfer (
        .clock      (clock),
        .reset      (reset),
        .wdtTick    (wdtTick),
        .startXfer  (ctrlTake),
        .startValue (pwdata[7:0]),
        .bootLoad   (bootLoad),
        .bootValue  (bootWatchdogFuse),
        .busy       (busy),
        .settled    (settled)
    );

    // Kick crossing; a halted processor flushes a pending kick
    // One kick is carried at a time; a second one meanwhile is dropped
    wwdc_kick_sync u_kick (
        .clock     (clock),
        .reset     (reset),
        .wdtTick   (wdtTick),
        .kickReq   (watchdogKick),
        .flush     (cpuHalted),
        .kickApply (kickApply),
        .kickBusy  (kickBusy)
    );

    // Lengths of the settings in force
    // Limitation: lengths count wdtTick pulses, so the timeouts are only
    // as accurate as the watchdog time base
    // closed length from window code
    wire [13:0] openLen   = wwdc_ticks(settled[`WWDC_PERIOD_MSB:`WWDC_PERIOD_LSB]);
    wire [13:0] closedLen = wwdc_ticks(settled[`WWDC_WINDOW_MSB:`WWDC_WINDOW_LSB]);
    wire        enabled   = (openLen != 14'h0000);
    wire        windowOn  = (closedLen != 14'h0000);
    wire        openEnd   = (count_reg == openLen - 14'h0001);
    wire        closedEnd = (count_reg == closedLen - 14'h0001);

    // Timer next state; the first period after enable or halt is open
    // A kick and a timeout tick in one cycle count as a kick
    always_comb begin
        phase_next = phase_reg;
        count_next = count_reg;
        fire       = 1'b0;
        if (!enabled) begin
            phase_next = WWDC_OFF;
            count_next = 14'h0000;
        end else if (cpuHalted) begin
            // Halted processor: count held at zero, open phase next
            phase_next = WWDC_OPEN;
            count_next = 14'h0000;
        end else begin
            unique case (phase_reg)
                WWDC_OFF: begin
                    phase_next = WWDC_OPEN;
                    count_next = 14'h0000;
                end
                WWDC_OPEN: begin
                    if (kickApply) begin
                        phase_next = windowOn ? WWDC_CLOSED : WWDC_OPEN;
                        count_next = 14'h0000;
                    end else if (wdtTick && openEnd) begin
                        fire       = 1'b1;
                        count_next = 14'h0000;
                    end else if (wdtTick) begin
                        count_next = count_reg + 14'h0001;
                    end
                end
                WWDC_CLOSED: begin
                    if (kickApply) begin
                        fire       = 1'b1;
                        phase_next = WWDC_OPEN;
                        count_next = 14'h0000;
                    end else if (!windowOn) begin
                        // Window switched off mid-period: fall back to open
                        phase_next = WWDC_OPEN;
                        count_next = 14'h0000;
                    end else if (wdtTick && closedEnd) begin
                        phase_next = WWDC_OPEN;
                        count_next = 14'h0000;
                    end else if (wdtTick) begin
                        count_next = count_reg + 14'h0001;
                    end
                end
            endcase
        end
    end

    // Timer registers
    // fire is registered so the reset request cannot glitch
    always_ff @(posedge clock) begin
        if (reset) begin
            phase_reg <= WWDC_OFF;
            count_reg <= 14'h0000;
            fire_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            count_reg <= count_next;
            fire_reg  <= fire;
        end
    end

    // One-cycle system reset request, from a flip-flop
    assign systemResetReq = fire_reg;

    // Checks next to the logic they guard
    a_lock_holds_ctrl: assert property (@(posedge clock) disable iff (reset)
        lock_reg && wrCtrl && !boot_reg |=> control_reg == $past(control_reg))
        else $error("locked control register changed");

    a_lock_stays_set: assert property (@(posedge clock) disable iff (reset)
        lock_reg && !debugMode |=> lock_reg)
        else $error("lock cleared outside debug");

    a_boot_sets_lock: assert property (@(posedge clock) disable iff (reset)
        boot_reg && fusePeriod != 4'h0 |=> lock_reg && control_reg == $past(bootWatchdogFuse))
        else $error("boot did not load fuse or set lock");

    a_guard_needed: assert property (@(posedge clock) disable iff (reset)
        !guardOpen && !boot_reg |=> $stable(lock_reg) && $stable(control_reg))
        else $error("protected state changed without unlock");

    a_busy_follows: assert property (@(posedge clock) disable iff (reset)
        ctrlTake |=> busy ##0 statusWord[`WWDC_BUSY_BIT])
        else $error("busy not raised after control write");

    a_status_reset: assert property (@(posedge clock) disable iff (reset)
        $fell(reset) |-> statusWord == `WWDC_STATUS_RST)
        else $error("status not zero after reset");

    a_timeout_fires: assert property (@(posedge clock) disable iff (reset)
        phase_reg == WWDC_OPEN && enabled && !cpuHalted && !kickApply && wdtTick && openEnd
        |=> systemResetReq ##1 !systemResetReq)
        else $error("timeout did not give one reset pulse");

    a_closed_kick: assert property (@(posedge clock) disable iff (reset)
        phase_reg == WWDC_CLOSED && enabled && !cpuHalted && kickApply |=> systemResetReq)
        else $error("closed kick did not reset");

    a_window_enter: assert property (@(posedge clock) disable iff (reset)
        phase_reg == WWDC_OPEN && enabled && windowOn && !cpuHalted && kickApply
        |=> phase_reg == WWDC_CLOSED && count_reg == 14'h0000)
        else $error("window not entered on open kick");

    a_closed_length: assert property (@(posedge clock) disable iff (reset)
        phase_reg == WWDC_CLOSED && enabled && windowOn && !cpuHalted && !kickApply
        && wdtTick && closedEnd |=> phase_reg == WWDC_OPEN)
        else $error("closed period length wrong");

    a_disabled_off: assert property (@(posedge clock) disable iff (reset)
        !enabled |=> phase_reg == WWDC_OFF && !systemResetReq)
        else $error("disabled or reserved period still counting");

    // Checks on boot, guard, kick crossing, halt and open kick restart
    a_boot_loads_ctrl: assert property (@(posedge clock) disable iff (reset)
        boot_reg |=> control_reg == $past(bootWatchdogFuse)
        && settled == $past(bootWatchdogFuse))
        else $error("boot did not load fuse into control");

    a_guard_key_opens: assert property (@(posedge clock) disable iff (reset)
        keyWrite |=> guard_reg == `WWDC_GUARD_SPAN)
        else $error("key write did not open guard");

    a_kick_held: assert property (@(posedge clock) disable iff (reset)
        kickBusy && !cpuHalted && !kickApply |=> kickBusy)
        else $error("pending kick lost before it landed");

    a_halt_holds: assert property (@(posedge clock) disable iff (reset)
        enabled && cpuHalted |=> phase_reg == WWDC_OPEN && count_reg == 14'h0000
        && !kickBusy && !systemResetReq)
        else $error("halt did not clear count or drop kick");

    a_kick_restarts: assert property (@(posedge clock) disable iff (reset)
        phase_reg == WWDC_OPEN && enabled && !windowOn && !cpuHalted && kickApply
        |=> phase_reg == WWDC_OPEN && count_reg == 14'h0000 && !systemResetReq)
        else $error("open kick did not restart timeout");
endmodule

// *** wwdc_top_bench.sv ***
// Self-checking bench for the windowed watchdog control block.
// Assumes the package and constants header compile before this file.
`timescale 1ns/10ps
`include "wwdc_cfg.svh"
module wwdc_top_bench
    import wwdc_pkg::*;
;
    // Compare one value, count it, report a mismatch at once
    `define CHK(what, exp, got) begin numChecks++; if ((got) !== (exp)) begin errCount++; \
        $display("ERROR %s expected %0h seen %0h", what, exp, got); end end

    // Byte addresses: four times the register index
    localparam logic [3:0] ADDR_CTL  = {`WWDC_IDX_CONTROL, 2'h0};
    localparam logic [3:0] ADDR_STAT = {`WWDC_IDX_STATUS, 2'h0};
    localparam logic [3:0] ADDR_KEY  = {`WWDC_IDX_GUARD, 2'h0};

    // Design stimulus and responses
    logic        clock            = 1'b0;
    logic        reset            = 1'b1;
    logic        psel             = 1'b0;
    logic        penable          = 1'b0;
    logic        pwrite           = 1'b0;
    logic [3:0]  paddr            = 4'h0;
    logic [31:0] pwdata           = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  bootWatchdogFuse = 8'h00;
    logic        debugMode        = 1'b0;
    logic        cpuHalted        = 1'b0;
    logic        wdtTick          = 1'b0;
    logic        watchdogKick     = 1'b0;
    logic        systemResetReq;
    // Bench counters
    int          errCount         = 0;
    int          numChecks        = 0;
    int          resetCount       = 0;
    logic [31:0] rdVal;
    logic        rdErr;

    // 50 MHz system clock
    always #10 clock = ~clock;

    // Count every system reset pulse the block issues
    always @(posedge clock) begin
        if (systemResetReq === 1'b1) begin
            resetCount++;
        end
    end

    wwdc_top i_dut (
        .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bootWatchdogFuse(bootWatchdogFuse), .debugMode(debugMode),
        .cpuHalted(cpuHalted), .wdtTick(wdtTick), .watchdogKick(watchdogKick),
        .systemResetReq(systemResetReq)
    );

    // Verdict and end of run; also reached when a wait runs out
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int i;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (pready === 1'b1) begin
                break;
            end
        end
        // A slave that never answers ends the run
        if (i == 50) begin
            errCount++;
            $display("ERROR pready expected 1 seen timeout");
            close_out();
        end
        rdVal   = prdata;
        rdErr   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read a register and compare its whole word
    task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
        logic [31:0] want;
        want = {24'h000000, exp};
        apb(1'b0, a, 8'h00);
        `CHK(what, want, rdVal)
    endtask

    // Watchdog time base: pulses spaced a few system cycles apart
    task automatic tick(input int n);
        repeat (n) begin
            repeat (3) @(posedge clock);
            wdtTick <= 1'b1;
            @(posedge clock);
            wdtTick <= 1'b0;
        end
    endtask

    // One-cycle kick pulse
    task automatic kick;
        @(posedge clock);
        watchdogKick <= 1'b1;
        @(posedge clock);
        watchdogKick <= 1'b0;
    endtask

    // Guarded control write, then let the transfer finish
    task automatic setctl(input logic [7:0] d);
        apb(1'b1, ADDR_KEY, `WWDC_GUARD_KEY);
        apb(1'b1, ADDR_CTL, d);
        tick(2);
    endtask

    // Reset held for 12 cycles, then the boot cycle passes
    task automatic do_reset;
        reset <= 1'b1;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    // Reset values, register map and unmapped places
    task automatic t_map;
        rdchk("control boot", ADDR_CTL, 8'h00);
        rdchk("status reset", ADDR_STAT, 8'h00);
        apb(1'b0, 4'hC, 8'h00);
        `CHK("unmapped err", 1'b1, rdErr)
        `CHK("unmapped data", 32'h00000000, rdVal)
        $display("Test map done");
    endtask

    // Unguarded write refused; busy rises and clears on the 2nd tick
    task automatic t_busy;
        apb(1'b1, ADDR_CTL, 8'h13);
        rdchk("unguarded ctl", ADDR_CTL, 8'h00);
        apb(1'b1, ADDR_KEY, `WWDC_GUARD_KEY);
        apb(1'b1, ADDR_CTL, 8'h13);
        rdchk("busy set", ADDR_STAT, 8'h01);
        tick(1);
        rdchk("busy one tick", ADDR_STAT, 8'h01);
        tick(1);
        rdchk("busy clear", ADDR_STAT, 8'h00);
        rdchk("control value", ADDR_CTL, 8'h13);
        setctl(8'h00);
        $display("Test busy done");
    endtask

    // Kicks keep the timeout away; silence then brings a reset
    task automatic t_normal;
        setctl(8'h01);
        resetCount = 0;
        repeat (3) begin
            kick();
            tick(4);
        end
        tick(3);
        `CHK("no reset kicked", 0, resetCount)
        tick(5);
        `CHK("timeout reset", 1, resetCount)
        setctl(8'h00);
        $display("Test normal done");
    endtask

    // Kick in open phase is fine; kick in the closed period resets
    task automatic t_window;
        setctl(8'h11);
        resetCount = 0;
        kick();
        tick(3);
        `CHK("open kick", 0, resetCount)
        kick();
        tick(3);
        `CHK("closed kick", 1, resetCount)
        setctl(8'h00);
        $display("Test window done");
    endtask

    // Halt clears the count and drops a pending kick
    task automatic t_halt;
        setctl(8'h01);
        resetCount = 0;
        tick(6);
        kick();
        cpuHalted <= 1'b1;
        tick(3);
        cpuHalted <= 1'b0;
        tick(7);
        `CHK("halt restart", 0, resetCount)
        tick(2);
        `CHK("halt timeout", 1, resetCount)
        setctl(8'h00);
        $display("Test halt done");
    endtask

    // Reserved codes read back as written but keep the timer off
    task automatic t_reserved;
        setctl(8'hCC);
        rdchk("reserved rb", ADDR_CTL, 8'hCC);
        resetCount = 0;
        tick(20);
        `CHK("reserved off", 0, resetCount)
        setctl(8'h00);
        $display("Test reserved done");
    endtask

    // Lock set by software, blocks control, clears in debug only
    task automatic t_lock;
        apb(1'b1, ADDR_KEY, `WWDC_GUARD_KEY);
        apb(1'b1, ADDR_STAT, 8'h80);
        rdchk("lock set", ADDR_STAT, 8'h80);
        setctl(8'h05);
        rdchk("locked ctl", ADDR_CTL, 8'h00);
        apb(1'b1, ADDR_KEY, `WWDC_GUARD_KEY);
        apb(1'b1, ADDR_STAT, 8'h00);
        rdchk("lock no debug", ADDR_STAT, 8'h80);
        debugMode <= 1'b1;
        apb(1'b1, ADDR_KEY, `WWDC_GUARD_KEY);
        apb(1'b1, ADDR_STAT, 8'h00);
        rdchk("lock debug clr", ADDR_STAT, 8'h00);
        debugMode <= 1'b0;
        rdchk("guard left", ADDR_KEY, 8'h02);
        rdchk("guard last", ADDR_KEY, 8'h01);
        apb(1'b1, ADDR_STAT, 8'h80);
        rdchk("lock unguarded", ADDR_STAT, 8'h00);
        $display("Test lock done");
    endtask

    // Second reset with an enabling fuse: control loads, lock sets
    task automatic t_fuse;
        bootWatchdogFuse <= 8'h21;
        do_reset();
        rdchk("fuse control", ADDR_CTL, 8'h21);
        rdchk("fuse lock", ADDR_STAT, 8'h80);
        $display("Test fuse done");
    endtask

    // Main sequence
    initial begin
        do_reset();
        t_map();
        t_busy();
        t_normal();
        t_window();
        t_halt();
        t_reserved();
        t_lock();
        t_fuse();
        close_out();
    end
endmodule
